// ===== auth_key_engine.sv
/*
 * Authentication and key-derivation engine: zero-pads a secret key and
 * two public inputs, then runs two chained AES-128 encryptions, one
 * round per clock, with registers on an AXI4-Lite slave.
 * Assumes one 20 MHz clock, an asynchronous active-high reset and a
 * master that keeps the inputs steady while a run is in progress.
 */
// Implementation choices: the register addresses and the AXI4-Lite slave port.
// Function
// - Secret input of 1 to 128 bits
// - First public input up to 64 bits
// - Second public input up to 64 bits
// - 128-bit result: session key or tag+key
// - Two selectable modes: session or tag
// - Key holds secret bits, zeros after m
// - Plaintext bits 0..63 from first input
// - Plaintext bits 64..127 from second input
// - First AES pass of padded plaintext
// - Session mode re-encrypts first ciphertext
// - Session mode outputs all 128 bits
// - Tag is first ciphertext bits 0..31
// - Tag mode flips bit 127 before pass two
// - Derived key is leading t bits
// - Bit 0 is the leftmost, most significant
module auth_key_engine (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic done
);
    // One AES round; the last round skips the column mix
    function automatic logic [127:0] enc_round(input logic [127:0] s,
        input logic [127:0] rk, input logic last);
        logic [7:0] b [16];
        logic [7:0] a0, a1, a2, a3;
        logic [127:0] o;
        for (int i = 0; i < 16; i++)
            b[i] = auth_key_pkg::sbox(
                s[127 - 8 * (4 * ((i / 4 + i % 4) % 4) + i % 4) -: 8]);
        for (int c = 0; c < 4; c++)
        begin
            a0 = b[4 * c];
            a1 = b[4 * c + 1];
            a2 = b[4 * c + 2];
            a3 = b[4 * c + 3];
            if (last)
                o[127 - 32 * c -: 32] = {a0, a1, a2, a3};
            else
                o[127 - 32 * c -: 32] = {
                    auth_key_pkg::xtime(a0 ^ a1) ^ a1 ^ a2 ^ a3,
                    auth_key_pkg::xtime(a1 ^ a2) ^ a2 ^ a3 ^ a0,
                    auth_key_pkg::xtime(a2 ^ a3) ^ a3 ^ a0 ^ a1,
                    auth_key_pkg::xtime(a3 ^ a0) ^ a0 ^ a1 ^ a2};
        end
        return o ^ rk;
    endfunction

    function automatic logic [127:0] next_key(input logic [127:0] k,
        input logic [7:0] rc);
        logic [31:0] t, n0, n1, n2;
        t = {auth_key_pkg::sbox(k[23:16]) ^ rc, auth_key_pkg::sbox(k[15:8]),
             auth_key_pkg::sbox(k[7:0]), auth_key_pkg::sbox(k[31:24])};
        n0 = k[127:96] ^ t;
        n1 = k[95:64] ^ n0;
        n2 = k[63:32] ^ n1;
        return {n0, n1, n2, k[31:0] ^ n2};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[8 * i +: 8] = nw[8 * i +: 8];
        return r;
    endfunction

    // Bus side state
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d, len_q, len_d;
    logic cfg_mode_q, cfg_mode_d, start_q, start_d;
    logic [31:0] in_q [8];
    logic [31:0] in_d [8];
    logic [7:0] ra, wa;
    logic [2:0] ri, wi;

    // Engine state
    auth_key_pkg::eng_state_t state_q, state_d;
    logic [3:0] round_q, round_d;
    logic [7:0] rcon_q, rcon_d;
    logic [127:0] st_q, st_d, rk_q, rk_d, key_q, key_d, w_q, w_d;
    logic [127:0] res_q, res_d;
    logic [31:0] tag_q, tag_d;
    logic mode_q, mode_d, done_q, done_d;
    logic [7:0] tlen_q, tlen_d;
    logic go, last_round;
    logic [127:0] kmask, pmask, tmask, key_pad, nk, aes_out;

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign done = done_q;

    always_comb
    begin
        awready_d = awready_q;
        aw_have_d = aw_have_q;
        aw_addr_d = aw_addr_q;
        w_have_d = w_have_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = bvalid_q && !bready;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q && !rready;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        len_d = len_q;
        cfg_mode_d = cfg_mode_q;
        start_d = 1'b0;
        in_d = in_q;
        ra = {araddr[7:2], 2'b00};
        wa = {aw_addr_q[7:2], 2'b00};
        ri = 3'((ra - auth_key_pkg::SEC_OFS) >> 2);
        wi = 3'((wa - auth_key_pkg::SEC_OFS) >> 2);
        // Address and data are parked separately so either may come first
        if (awvalid && awready_q)
        begin
            aw_have_d = 1'b1;
            aw_addr_d = awaddr;
        end
        if (wvalid && wready_q)
        begin
            w_have_d = 1'b1;
            w_data_d = wdata;
            w_strb_d = wstrb;
        end
        if (aw_have_q && w_have_q && !bvalid_q)
        begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = auth_key_pkg::RESP_OKAY;
            if (wa == auth_key_pkg::CTRL_OFS)
            begin
                if (w_strb_q[0])
                begin
                    cfg_mode_d = w_data_q[auth_key_pkg::CTRL_MODE_BIT];
                    start_d = w_data_q[auth_key_pkg::CTRL_START_BIT];
                end
            end
            else if (wa == auth_key_pkg::LEN_OFS)
                len_d = merge(len_q, w_data_q, w_strb_q);
            else if (wa >= auth_key_pkg::SEC_OFS && wa < auth_key_pkg::RES_OFS)
                in_d[wi] = merge(in_q[wi], w_data_q, w_strb_q);
            else if (!(wa == auth_key_pkg::STAT_OFS || wa ==
                     auth_key_pkg::TAG_OFS || (wa > auth_key_pkg::RES_OFS &&
                     wa < auth_key_pkg::TAG_OFS) || wa == auth_key_pkg::RES_OFS))
                bresp_d = auth_key_pkg::RESP_SLVERR;
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        if (arvalid && arready_q)
        begin
            rvalid_d = 1'b1;
            rresp_d = auth_key_pkg::RESP_OKAY;
            rdata_d = 32'h0;
            if (ra == auth_key_pkg::CTRL_OFS)
                rdata_d[auth_key_pkg::CTRL_MODE_BIT] = cfg_mode_q;
            else if (ra == auth_key_pkg::STAT_OFS)
                rdata_d = {30'h0, state_q != auth_key_pkg::ST_IDLE, done_q};
            else if (ra == auth_key_pkg::LEN_OFS)
                rdata_d = len_q;
            else if (ra >= auth_key_pkg::SEC_OFS && ra < auth_key_pkg::RES_OFS)
                rdata_d = in_q[ri];
            else if (ra >= auth_key_pkg::RES_OFS && ra < auth_key_pkg::TAG_OFS)
                rdata_d = res_q[127 - 32 * int'(ri[1:0]) -: 32];
            else if (ra == auth_key_pkg::TAG_OFS)
                rdata_d = tag_q;
            else
                rresp_d = auth_key_pkg::RESP_SLVERR;
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= auth_key_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= auth_key_pkg::RESP_OKAY;
            rdata_q <= 32'h0;
            len_q <= auth_key_pkg::LEN_RST;
            cfg_mode_q <= 1'b0;
            start_q <= 1'b0;
            in_q <= '{default: 32'h0};
        end
        else
        begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            len_q <= len_d;
            cfg_mode_q <= cfg_mode_d;
            start_q <= start_d;
            in_q <= in_d;
        end
    end

    // Word 0 of each input is bits 0..31, so bit 0 lands in the vector MSB;
    // a length past its maximum shifts the mask out and saturates it
    assign kmask = ~({128{1'b1}} >> len_q[auth_key_pkg::LEN_M_LSB +: 8]);
    assign pmask = {~({64{1'b1}} >> len_q[auth_key_pkg::LEN_N_LSB +: 7]),
                    ~({64{1'b1}} >> len_q[auth_key_pkg::LEN_R_LSB +: 7])};
    assign tmask = ~({128{1'b1}} >> tlen_q);
    assign key_pad = {in_q[0], in_q[1], in_q[2], in_q[3]} & kmask;
    assign go = start_q && state_q == auth_key_pkg::ST_IDLE;
    assign last_round = round_q == auth_key_pkg::AES_ROUNDS;
    assign nk = next_key(rk_q, rcon_q);
    assign aes_out = enc_round(st_q, nk, last_round);

    always_comb
    begin
        state_d = state_q;
        round_d = round_q + 4'h1;
        rcon_d = auth_key_pkg::xtime(rcon_q);
        st_d = aes_out;
        rk_d = nk;
        key_d = key_q;
        w_d = w_q;
        res_d = res_q;
        tag_d = tag_q;
        mode_d = mode_q;
        done_d = done_q;
        tlen_d = tlen_q;
        case (state_q)
            auth_key_pkg::ST_IDLE:
            begin
                st_d = st_q;
                rk_d = rk_q;
                round_d = round_q;
                rcon_d = rcon_q;
                // A start while busy is dropped; results stay until restart
                if (go)
                begin
                    key_d = key_pad;
                    rk_d = key_pad;
                    st_d = ({in_q[4], in_q[5], in_q[6], in_q[7]} & pmask)
                        ^ key_pad;
                    round_d = 4'h1;
                    rcon_d = auth_key_pkg::RCON_INIT;
                    mode_d = cfg_mode_q;
                    tlen_d = len_q[auth_key_pkg::LEN_T_LSB +: 8];
                    done_d = 1'b0;
                    state_d = auth_key_pkg::ST_FIRST;
                end
            end
            auth_key_pkg::ST_FIRST:
            begin
                if (last_round)
                begin
                    w_d = aes_out;
                    tag_d = aes_out[127:96];
                    st_d = aes_out ^ {127'h0, mode_q} ^ key_q;
                    rk_d = key_q;
                    round_d = 4'h1;
                    rcon_d = auth_key_pkg::RCON_INIT;
                    state_d = auth_key_pkg::ST_SECOND;
                end
            end
            auth_key_pkg::ST_SECOND:
            begin
                if (last_round)
                begin
                    res_d = mode_q ? (aes_out & tmask) : aes_out;
                    done_d = 1'b1;
                    state_d = auth_key_pkg::ST_IDLE;
                end
            end
            default:
                state_d = auth_key_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= auth_key_pkg::ST_IDLE;
            round_q <= 4'h0;
            rcon_q <= auth_key_pkg::RCON_INIT;
            st_q <= 128'h0;
            rk_q <= 128'h0;
            key_q <= 128'h0;
            w_q <= 128'h0;
            res_q <= 128'h0;
            tag_q <= 32'h0;
            mode_q <= 1'b0;
            done_q <= 1'b0;
            tlen_q <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            round_q <= round_d;
            rcon_q <= rcon_d;
            st_q <= st_d;
            rk_q <= rk_d;
            key_q <= key_d;
            w_q <= w_d;
            res_q <= res_d;
            tag_q <= tag_d;
            mode_q <= mode_d;
            done_q <= done_d;
            tlen_q <= tlen_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_go;
        start_q && state_q == auth_key_pkg::ST_IDLE;
    endsequence
    sequence s_quiet;
        !done_q [*8];
    endsequence

    a_done_timing: assert property (s_go |-> ##1 s_quiet ##12 !done_q
        ##1 done_q) else $error("done not 21 cycles after start");
    a_first_pass: assert property (s_go |=>
        (state_q == auth_key_pkg::ST_FIRST) [*8] ##2
        state_q == auth_key_pkg::ST_FIRST ##1
        state_q == auth_key_pkg::ST_SECOND)
        else $error("first pass not ten rounds");
    a_key_padding: assert property (s_go |=>
        (key_q & ~$past(kmask)) == 128'h0 && rk_q == key_q)
        else $error("key bits past m not zero");
    a_text_padding: assert property (s_go |=>
        ((st_q ^ key_q) & ~$past(pmask)) == 128'h0)
        else $error("plaintext padding not zero");
    a_second_input: assert property (
        state_q == auth_key_pkg::ST_FIRST && last_round |=>
        st_q == (w_q ^ {127'h0, mode_q} ^ key_q) && rk_q == key_q)
        else $error("second pass input wrong");
    a_tag_word: assert property ($rose(done_q) && mode_q |->
        tag_q == w_q[127:96]) else $error("tag not first ciphertext word");
    a_key_trunc: assert property ($rose(done_q) && mode_q |->
        (res_q & ~tmask) == 128'h0) else $error("derived key not cut to t");
    a_session_full: assert property ($rose(done_q) && !mode_q |->
        res_q == $past(aes_out)) else $error("session key altered");
    a_result_hold: assert property (done_q && !start_q |=>
        done_q && $stable(res_q) && $stable(tag_q))
        else $error("result changed before restart");
    a_busy_start: assert property (
        state_q != auth_key_pkg::ST_IDLE && start_q |=> $stable(mode_q))
        else $error("start taken while busy");
    a_bresp_hold: assert property (bvalid_q && !bready |=>
        bvalid_q && $stable(bresp_q)) else $error("write response dropped");
endmodule

// ===== auth_key_pkg.sv
/*
 * Shared constants for the AES-based authentication and key-derivation
 * engine: register map, field layout, reset values, engine states and
 * the AES substitution table.
 * Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
 */
package auth_key_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] LEN_OFS = 8'h08;
    localparam logic [7:0] SEC_OFS = 8'h10;
    localparam logic [7:0] RES_OFS = 8'h30;
    localparam logic [7:0] TAG_OFS = 8'h40;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_MODE_BIT = 1;
    localparam int LEN_M_LSB = 0;
    localparam int LEN_N_LSB = 8;
    localparam int LEN_R_LSB = 16;
    localparam int LEN_T_LSB = 24;
    localparam logic [31:0] LEN_RST = 32'h80404080;
    localparam logic [3:0] AES_ROUNDS = 4'ha;
    localparam logic [7:0] RCON_INIT = 8'h01;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_SECOND} eng_state_t;

    localparam logic [2047:0] SBOX_TBL = {
        128'h637c777bf26b6fc53001672bfed7ab76,
        128'hca82c97dfa5947f0add4a2af9ca472c0,
        128'hb7fd9326363ff7cc34a5e5f171d83115,
        128'h04c723c31896059a071280e2eb27b275,
        128'h09832c1a1b6e5aa0523bd6b329e32f84,
        128'h53d100ed20fcb15b6acbbe394a4c58cf,
        128'hd0efaafb434d338545f9027f503c9fa8,
        128'h51a3408f929d38f5bcb6da2110fff3d2,
        128'hcd0c13ec5f974417c4a77e3d645d1973,
        128'h60814fdc222a908846eeb814de5e0bdb,
        128'he0323a0a4906245cc2d3ac629195e479,
        128'he7c8376d8dd54ea96c56f4ea657aae08,
        128'hba78252e1ca6b4c6e8dd741f4bbd8b8a,
        128'h703eb5664803f60e613557b986c11d9e,
        128'he1f8981169d98e949b1e87e9ce5528df,
        128'h8ca1890dbfe6426841992d0fb054bb16};

    function automatic logic [7:0] sbox(input logic [7:0] x);
        return SBOX_TBL[2047 - 8 * int'(x) -: 8];
    endfunction

    function automatic logic [7:0] xtime(input logic [7:0] x);
        return {x[6:0], 1'b0} ^ (x[7] ? 8'h1b : 8'h00);
    endfunction
endpackage

// ===== host_master.sv
/*
 * Host controller model: an AXI4-Lite master that feeds the engine.
 * Assumes one clock; every output changes by non-blocking assignment
 * just after a rising edge and is held until its channel is taken.
 */
module host_master (
    input wire logic clk,
    output logic awvalid,
    input wire logic awready,
    output logic [7:0] awaddr,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    output logic arvalid,
    input wire logic arready,
    output logic [7:0] araddr,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        awvalid = 1'b0;
        awaddr = 8'h00;
        wvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'hf;
        bready = 1'b0;
        arvalid = 1'b0;
        araddr = 8'h00;
        rready = 1'b0;
    end

    // Outputs are registers, so a read right after the edge sees the
    // values that the edge sampled
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] resp);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awvalid && awready)
            begin
                awvalid <= 1'b0;
                // A released bus shows garbage, never the old value
                awaddr <= ~a;
            end
            if (wvalid && wready)
            begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] resp);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arvalid && arready)
            begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
        end
        while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
endmodule

// ===== testbench.sv
/*
 * Self-checking bench for the key-derivation engine, using known
 * answer vectors in both modes through the host bus model.
 * Assumes the engine's register map and its fixed start-to-done latency.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk;
    logic sys_rst;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, done;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rr;
    int fail_count;
    int samples_checked;

    auth_key_engine u_auth_key_engine (
        .clk(clk), .sys_rst(sys_rst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .done(done));

    host_master u_host_master (
        .clk(clk), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp,
                     seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", samples_checked,
                 fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        string s = $sformatf("word at %h", a);
        u_host_master.rd(a, rv, rr);
        check(s, rv, exp);
        check({s, " resp"}, {30'h0, rr}, 32'h0);
    endtask

    // Words hold bits 0..31 from the top down, so hex maps straight
    task automatic load(input logic [127:0] k, input logic [63:0] p1,
                        input logic [63:0] p2, input logic [31:0] len);
        for (int i = 0; i < 4; i++)
            u_host_master.wr(auth_key_pkg::SEC_OFS + 8'(4 * i),
                             k[127 - 32 * i -: 32], rr);
        for (int i = 0; i < 2; i++)
        begin
            u_host_master.wr(auth_key_pkg::SEC_OFS + 8'(16 + 4 * i),
                             p1[63 - 32 * i -: 32], rr);
            u_host_master.wr(auth_key_pkg::SEC_OFS + 8'(24 + 4 * i),
                             p2[63 - 32 * i -: 32], rr);
        end
        u_host_master.wr(auth_key_pkg::LEN_OFS, len, rr);
    endtask

    task automatic run(input logic [31:0] ctrl);
        int n;
        u_host_master.wr(auth_key_pkg::CTRL_OFS, ctrl, rr);
        @(posedge clk);
        check("done after start", {31'h0, done}, 32'h0);
        n = 0;
        // Bus stays quiet so the inputs cannot move under the engine
        while (done !== 1'b1 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
        check("run cycles", n, 20);
    endtask

    task automatic check_res(input logic [127:0] e);
        for (int i = 0; i < 4; i++)
            rdchk(auth_key_pkg::RES_OFS + 8'(4 * i), e[127 - 32 * i -: 32]);
    endtask

    initial
    begin
        fail_count = 0;
        samples_checked = 0;
        sys_rst = 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check("done at reset", {31'h0, done}, 32'h0);
        rdchk(auth_key_pkg::LEN_OFS, auth_key_pkg::LEN_RST);
        u_host_master.rd(8'h80, rv, rr);
        check("unmapped read data", rv, 32'h0);
        check("unmapped read resp", {30'h0, rr}, 32'h2);
        u_host_master.wr(8'h84, 32'h1, rr);
        check("unmapped write resp", {30'h0, rr}, 32'h2);
        // Full lengths, session mode
        load(128'h42025ee339743af647b5778025e9b66d, 64'ha0f3624e949640a0,
             64'h17da4751f5b2b180, 32'h80404080);
        run(32'h1);
        check_res(128'h294016c034cd1a5576081826366a7e4a);
        rdchk(auth_key_pkg::STAT_OFS, 32'h1);
        u_host_master.wr(auth_key_pkg::RES_OFS, 32'hffffffff, rr);
        check("result write resp", {30'h0, rr}, 32'h0);
        rdchk(auth_key_pkg::RES_OFS, 32'h294016c0);
        // Short lengths with junk beyond each length, which must be masked
        load(128'hbcd32db021d5d00993428051f1cc37ff, 64'h10439453b0b8733f,
             64'hafe2c12d7dc18fff, 32'h80383c78);
        run(32'h1);
        check_res(128'hce6aaedbe96cdce78650116cdd109180);
        // Tag mode, derived key cut to 40 bits
        load(128'h42025ee339743af647b5778025e9b66d, 64'ha0f3624e949640a0,
             64'h17da4751f5b2b180, 32'h28404080);
        run(32'h3);
        rdchk(auth_key_pkg::TAG_OFS, 32'hfaa865e7);
        check_res({32'h4d485333, 32'h3c000000, 64'h0});
        rdchk(auth_key_pkg::CTRL_OFS, 32'h2);
        // Reset in mid-run abandons the run and clears every result flag
        u_host_master.wr(auth_key_pkg::CTRL_OFS, 32'h1, rr);
        repeat (5) @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check("done after reset", {31'h0, done}, 32'h0);
        rdchk(auth_key_pkg::STAT_OFS, 32'h0);
        rdchk(auth_key_pkg::LEN_OFS, auth_key_pkg::LEN_RST);
        rdchk(auth_key_pkg::CTRL_OFS, 32'h0);
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        finish_test();
    end
endmodule
